// file: hw/sp_mode_cfg.svh
// Purpose: Constants for the serial port mode control block
// Assumes: Included by bare name
// Notes:   Field positions of the 20-bit mode word
`ifndef SP_MODE_CFG_SVH
`define SP_MODE_CFG_SVH
`define SPM_WIDTH        20
`define SPM_RESET        20'h00000
`define SPM_RSVD_MASK    20'h78000
`define SPM_SPDIF_BIT    19
`define SPM_B_PREC_HI    14
`define SPM_A_PREC_HI    13
`define SPM_B_CLKSRC     12
`define SPM_B_MASTER     11
`define SPM_A_MASTER     10
`define SPM_B_TDM        9
`define SPM_A_TDM        8
`define SPM_B_CPOL       7
`define SPM_A_CPOL       6
`define SPM_B_FR_HI      5
`define SPM_B_FR_LO      3
`define SPM_A_FR_HI      2
`define SPM_A_FR_LO      0
`define BUF_DEPTH        2
`endif

// file: hw/sp_mode_pkg.sv
// Purpose: Types for the serial port mode control block
// Assumes: Constants live in sp_mode_cfg.svh
// Notes:   Precision and frame length encodings
package sp_mode_pkg;
   typedef enum logic [1:0] {PREC_20, PREC_18, PREC_16, PREC_24} precision_e;
   typedef logic [8:0] frame_len_t;
   typedef logic [19:0] mode_word_t;
endpackage : sp_mode_pkg

// file: hw/word_buffer.sv
// Purpose: Two-entry valid/ready buffer for mode words
// Assumes: Single clock, async active-low reset
// Notes:   Output data registered
`timescale 1ns/100ps
`include "sp_mode_cfg.svh"
module word_buffer
   import sp_mode_pkg::*;
(
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset_n,
   // Fill side
   input  wire logic       i_valid,
   input  wire mode_word_t i_data,
   output logic            o_ready,
   // Drain side
   output logic            o_valid,
   output mode_word_t      o_data,
   input  wire logic       i_ready
);
   typedef struct packed {
      mode_word_t [1:0] mem;
      logic             wp;
      logic             rp;
      logic [1:0]       cnt;
   } buf_s;
   buf_s st, next_st;
   always_comb begin
      next_st = st;
      if (i_valid && st.cnt != 2'h2) begin
         next_st.mem[st.wp] = i_data;
         next_st.wp = ~st.wp;
      end
      if (i_ready && st.cnt != 2'h0) begin
         next_st.rp = ~st.rp;
      end
      next_st.cnt = st.cnt + {1'b0, i_valid && st.cnt != 2'h2}
                    - {1'b0, i_ready && st.cnt != 2'h0};
   end
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign o_ready = st.cnt != 2'h2;
   assign o_valid = st.cnt != 2'h0;
   assign o_data  = st.mem[st.rp];
endmodule : word_buffer

// file: hw/serial_port_mode_ctrl.sv
// Purpose: Serial port mode register and group configuration decode
// Assumes: Register reached by parallel register transfers on the core clock
// Notes:   Channel flags follow sampled word-select pins
`timescale 1ns/100ps
`include "sp_mode_cfg.svh"
// Contract
// - Spdif bit makes port G transmitter
// - Group B precision from two bits
// - Group A precision from two bits
// - Clock source bit: PLL, drive shared pin
// - Group B master drives its bit clock
// - Group A master drives its bit clock
// - Group B TDM uses B frame size
// - Group A TDM uses A frame size
// - Group B polarity picks output edge
// - Group A polarity picks sample edge
// - Group B frame size code table
// - Group A frame size code table
// - Register reached only by transfers
// - Grouping bit assigns ports to groups
// - Group B word or frame sync
// - Channel flags report left or right
module serial_port_mode_ctrl
   import sp_mode_pkg::*;
(
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset_n,
   // Register transfer port
   input  wire logic       i_xfer_write,
   input  wire mode_word_t i_xfer_data,
   output logic            o_xfer_ready,
   output mode_word_t      o_serial_port_mode,
   // Other mode bits
   input  wire logic       i_grp_a_precision_lo,
   input  wire logic       i_grp_b_precision_lo,
   input  wire logic       i_port_grouping_select,
   input  wire logic       i_grp_b_sync_select,
   // Pins
   input  wire logic       i_grp_a_bit_clock,
   input  wire logic       i_grp_b_bit_clock,
   input  wire logic       i_grp_a_word_sel,
   input  wire logic       i_grp_b_word_sel,
   // Decoded configuration
   output logic            o_spdif_out_enable,
   output logic [1:0]      o_grp_a_precision,
   output logic [1:0]      o_grp_b_precision,
   // Clocking and framing
   output logic            o_shared_serial_clock_oe,
   output logic            o_grp_b_use_pll,
   output logic            o_grp_a_bit_clock_oe,
   output logic            o_grp_b_bit_clock_oe,
   output logic            o_grp_a_tdm,
   output logic            o_grp_b_tdm,
   output frame_len_t      o_grp_a_frame_len,
   output frame_len_t      o_grp_b_frame_len,
   // Edge pulses
   output logic            o_grp_a_sample_pulse,
   output logic            o_grp_b_launch_pulse,
   // Grouping and channel status
   output logic            o_port_f_in_grp_a,
   output logic            o_grp_b_word_sync,
   output logic            o_grp_a_channel_flag,
   output logic            o_grp_b_channel_flag
);

   typedef struct packed {
      // Register and transfer side
      mode_word_t mode;
      logic       xfer_rdy;
      // Pin synchronisers and edge history
      logic [1:0] sync_ca;
      logic [1:0] sync_cb;
      logic [1:0] sync_wa;
      logic [1:0] sync_wb;
      logic       prev_ca;
      logic       prev_cb;
      // Registered decode
      logic       spdif;
      precision_e prec_a;
      precision_e prec_b;
      logic       sck_oe;
      logic       use_pll;
      logic       a_oe;
      logic       b_oe;
      logic       tdm_a;
      logic       tdm_b;
      frame_len_t len_a;
      frame_len_t len_b;
      logic       samp_a;
      logic       launch_b;
      logic       f_in_a;
      logic       wsync_b;
      logic       ch_a;
      logic       ch_b;
   } ctrl_s;
   ctrl_s st, next_st;

   // Edge detect per group, index 0 is group A, 1 is group B
   for (genvar g = 0; g < 2; g++) begin : g_edge
      logic now_lvl;
      logic was_lvl;
      logic rise;
      logic fall;
      assign now_lvl = (g == 1) ? st.sync_cb[1] : st.sync_ca[1];
      assign was_lvl = (g == 1) ? st.prev_cb : st.prev_ca;
      assign rise    = now_lvl & ~was_lvl;
      assign fall    = ~now_lvl & was_lvl;
   end

   // Frame length per group; only meaningful while the group is master
   for (genvar g = 0; g < 2; g++) begin : g_frame
      logic [2:0] code;
      frame_len_t len;
      assign code = (g == 1) ? st.mode[`SPM_B_FR_HI:`SPM_B_FR_LO]
                             : st.mode[`SPM_A_FR_HI:`SPM_A_FR_LO];
      always_comb begin
         case (code)
            3'h0:    len = 9'h010;
            3'h1:    len = 9'h020;
            3'h2:    len = 9'h040;
            3'h3:    len = 9'h080;
            3'h4:    len = 9'h0c0;
            3'h5:    len = 9'h100;
            3'h6:    len = 9'h0c1;
            default: len = 9'h018;
         endcase
      end
   end

   logic       buf_valid;
   mode_word_t buf_data;
   logic       buf_in_ready;

   // Writes queue so a burst of transfers is never dropped
   word_buffer u_buf (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .i_valid   (i_xfer_write),
      .i_data    (i_xfer_data),
      .o_ready   (buf_in_ready),
      .o_valid   (buf_valid),
      .o_data    (buf_data),
      .i_ready   (1'b1)
   );

   always_comb begin
      next_st = st;
      next_st.xfer_rdy = buf_in_ready;
      // Two-flop sync; only the second stage feeds logic
      next_st.sync_ca = {st.sync_ca[0], i_grp_a_bit_clock};
      next_st.sync_cb = {st.sync_cb[0], i_grp_b_bit_clock};
      next_st.sync_wa = {st.sync_wa[0], i_grp_a_word_sel};
      next_st.sync_wb = {st.sync_wb[0], i_grp_b_word_sel};
      next_st.prev_ca = st.sync_ca[1];
      next_st.prev_cb = st.sync_cb[1];
      // Reserved bits never reach the register, so they read zero
      if (buf_valid) begin
         next_st.mode = buf_data & ~`SPM_RSVD_MASK;
      end
      next_st.spdif    = st.mode[`SPM_SPDIF_BIT];
      // Precision code is the low bit over the high bit
      case ({i_grp_b_precision_lo, st.mode[`SPM_B_PREC_HI]})
         2'h0:    next_st.prec_b = PREC_20;
         2'h1:    next_st.prec_b = PREC_18;
         2'h2:    next_st.prec_b = PREC_16;
         default: next_st.prec_b = PREC_24;
      endcase

      case ({i_grp_a_precision_lo, st.mode[`SPM_A_PREC_HI]})
         2'h0:    next_st.prec_a = PREC_20;
         2'h1:    next_st.prec_a = PREC_18;
         2'h2:    next_st.prec_a = PREC_16;
         default: next_st.prec_a = PREC_24;
      endcase
      next_st.use_pll  = st.mode[`SPM_B_CLKSRC];
      next_st.sck_oe   = st.mode[`SPM_B_CLKSRC];
      next_st.b_oe     = st.mode[`SPM_B_MASTER];
      next_st.a_oe     = st.mode[`SPM_A_MASTER];
      next_st.tdm_b    = st.mode[`SPM_B_TDM];
      next_st.tdm_a    = st.mode[`SPM_A_TDM];
      // Launch pulse lags the pin by the two sync flops plus this register, three clock edges
      next_st.launch_b = st.mode[`SPM_B_CPOL] ? g_edge[1].rise : g_edge[1].fall;
      next_st.samp_a   = st.mode[`SPM_A_CPOL] ? g_edge[0].fall : g_edge[0].rise;
      next_st.len_b    = g_frame[1].len;
      next_st.len_a    = g_frame[0].len;
      next_st.f_in_a   = ~i_port_grouping_select;
      next_st.wsync_b  = i_grp_b_sync_select;
      next_st.ch_a     = st.sync_wa[1];
      next_st.ch_b     = st.sync_wb[1];
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs leave the state flops directly
   assign o_xfer_ready             = st.xfer_rdy;
   assign o_serial_port_mode       = st.mode;
   assign o_spdif_out_enable       = st.spdif;
   assign o_grp_a_precision        = st.prec_a;
   assign o_grp_b_precision        = st.prec_b;
   assign o_shared_serial_clock_oe = st.sck_oe;
   assign o_grp_b_use_pll          = st.use_pll;
   assign o_grp_a_bit_clock_oe     = st.a_oe;
   assign o_grp_b_bit_clock_oe     = st.b_oe;
   assign o_grp_a_tdm              = st.tdm_a;
   assign o_grp_b_tdm              = st.tdm_b;
   assign o_grp_a_frame_len        = st.len_a;
   assign o_grp_b_frame_len        = st.len_b;
   assign o_grp_a_sample_pulse     = st.samp_a;
   assign o_grp_b_launch_pulse     = st.launch_b;
   assign o_port_f_in_grp_a        = st.f_in_a;
   assign o_grp_b_word_sync        = st.wsync_b;
   assign o_grp_a_channel_flag     = st.ch_a;
   assign o_grp_b_channel_flag     = st.ch_b;
endmodule : serial_port_mode_ctrl

// file: verification/serial_port_mode_ctrl_assertions.sv
// Purpose: Port checks for the serial port mode control block
// Assumes: Pin clocks far slower than the core clock
// Notes:   Pin to pulse latency allowed one to five cycles
`timescale 1ns/100ps
`include "sp_mode_cfg.svh"
module serial_port_mode_ctrl_assertions
   import sp_mode_pkg::*;
(
   input wire logic       i_ref_clk, i_reset_n, i_xfer_write, i_port_grouping_select,
   input wire logic       i_grp_a_bit_clock, i_grp_b_bit_clock, o_xfer_ready,
   input wire logic       o_spdif_out_enable, o_shared_serial_clock_oe, o_grp_b_use_pll,
   input wire logic       o_grp_a_bit_clock_oe, o_grp_b_bit_clock_oe, o_grp_a_tdm,
   input wire logic       o_grp_b_tdm, o_port_f_in_grp_a, o_grp_a_sample_pulse,
   input wire logic       o_grp_b_launch_pulse,
   input wire logic [1:0] o_grp_a_precision, o_grp_b_precision,
   input wire mode_word_t i_xfer_data, o_serial_port_mode,
   input wire frame_len_t o_grp_a_frame_len, o_grp_b_frame_len
);
   localparam frame_len_t LENS [8] = '{9'h010, 9'h020, 9'h040, 9'h080,
                                       9'h0c0, 9'h100, 9'h0c1, 9'h018};
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   sequence s_wr; i_xfer_write; endsequence
   sequence s_grp; $stable(i_port_grouping_select) [*3]; endsequence
   a_mode_write: assert property (s_wr |-> ##2
      o_serial_port_mode == ($past(i_xfer_data, 2) & ~`SPM_RSVD_MASK)) else $error("mode");
   a_spdif_out: assert property (s_wr |-> ##3
      o_spdif_out_enable == $past(i_xfer_data[19], 3)) else $error("spdif");
   a_precision_hi: assert property (s_wr |-> ##3
      {o_grp_b_precision[0], o_grp_a_precision[0]} == $past(i_xfer_data[14:13], 3))
      else $error("precision");
   a_clock_cfg: assert property (s_wr |-> ##3 {o_grp_b_use_pll,
      o_shared_serial_clock_oe, o_grp_b_bit_clock_oe, o_grp_a_bit_clock_oe, o_grp_b_tdm,
      o_grp_a_tdm} == {$past(i_xfer_data[12], 3), $past(i_xfer_data[12:8], 3)})
      else $error("clock config");
   a_frame_len: assert property (s_wr |-> ##3
      {o_grp_b_frame_len, o_grp_a_frame_len} == {LENS[$past(i_xfer_data[5:3], 3)],
      LENS[$past(i_xfer_data[2:0], 3)]}) else $error("frame length");
   // A wrong edge would pulse half a bit period later, outside the window
   a_sample_edge: assert property ((o_serial_port_mode[6] ? $fell(i_grp_a_bit_clock)
      : $rose(i_grp_a_bit_clock)) |-> ##[1:5] o_grp_a_sample_pulse) else $error("sample");
   a_launch_edge: assert property ((o_serial_port_mode[7] ? $rose(i_grp_b_bit_clock)
      : $fell(i_grp_b_bit_clock)) |-> ##[1:5] o_grp_b_launch_pulse) else $error("launch");
   a_port_grouping: assert property (s_grp |->
      o_port_f_in_grp_a == !i_port_grouping_select) else $error("grouping");
   a_reset_value: assert property ($rose(i_reset_n) |->
      o_serial_port_mode == 20'h00000 ##1 o_grp_a_frame_len == 9'h010) else $error("reset");
   a_xfer_ready: assert property ($past(i_reset_n) |-> o_xfer_ready)
      else $error("ready");
endmodule : serial_port_mode_ctrl_assertions
bind serial_port_mode_ctrl serial_port_mode_ctrl_assertions i_chk (.*);

// file: verification/audio_pins_model.sv
// Purpose: Converter side of the serial pins: bit clock and word select
// Assumes: Bit clock period 32 ns, edges fixed 1.3 ns after a falling core clock edge
// Notes:   Clock stands low while stopped, only whole periods are sent
`timescale 1ns/100ps
module audio_pins_model (
   input  wire logic i_run,
   output logic      o_bit_clock,
   output logic      o_word_sel
);
   int n;
   initial begin
      o_bit_clock = 1'b0;
      o_word_sel  = 1'b0;
      n           = 0;
      #1.3;
      forever begin
         #16;
         if (i_run) begin
            o_bit_clock = 1'b1;
            #16;
            o_bit_clock = 1'b0;
            n++;
            if (n % 16 == 0) o_word_sel = ~o_word_sel;
         end
      end
   end
endmodule : audio_pins_model

// file: verification/serial_port_mode_ctrl_tb_top.sv
// Purpose: Self-checking bench for the serial port mode control block
// Assumes: Inputs change on the falling core clock edge
// Notes:   One pin model feeds both groups, so edge counts match
`timescale 1ns/100ps
module serial_port_mode_ctrl_tb_top;
   import sp_mode_pkg::*;
   logic i_ref_clk, i_reset_n, i_xfer_write, i_grp_a_precision_lo, i_grp_b_precision_lo;
   logic i_port_grouping_select, i_grp_b_sync_select, i_grp_a_bit_clock, i_grp_b_bit_clock;
   logic i_grp_a_word_sel, i_grp_b_word_sel, o_xfer_ready, o_spdif_out_enable, run;
   logic o_shared_serial_clock_oe, o_grp_b_use_pll, o_grp_a_bit_clock_oe, o_grp_b_bit_clock_oe;
   logic o_grp_a_tdm, o_grp_b_tdm, o_grp_a_sample_pulse, o_grp_b_launch_pulse;
   logic o_port_f_in_grp_a, o_grp_b_word_sync, o_grp_a_channel_flag, o_grp_b_channel_flag;
   logic [1:0] o_grp_a_precision, o_grp_b_precision;
   mode_word_t i_xfer_data, o_serial_port_mode;
   frame_len_t o_grp_a_frame_len, o_grp_b_frame_len;
   int         bad_count, n_checks;
   localparam frame_len_t LENS [8] = '{9'h010, 9'h020, 9'h040, 9'h080,
                                       9'h0c0, 9'h100, 9'h0c1, 9'h018};
   localparam precision_e PRECS [4] = '{PREC_20, PREC_18, PREC_16, PREC_24};
   serial_port_mode_ctrl i_serial_port_mode_ctrl (.*);
   audio_pins_model i_audio_pins_model (.i_run(run), .o_bit_clock(i_grp_a_bit_clock),
                                        .o_word_sel(i_grp_a_word_sel));
   assign i_grp_b_bit_clock = i_grp_a_bit_clock;
   assign i_grp_b_word_sel  = i_grp_a_word_sel;
   initial begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input mode_word_t d);
      @(negedge i_ref_clk);
      i_xfer_write = 1'b1;
      i_xfer_data  = d;
      @(negedge i_ref_clk);
      i_xfer_write = 1'b0;
      repeat (3) @(negedge i_ref_clk);
   endtask : wr
   task automatic t_reset();
      wr(20'h0a5a5);
      i_reset_n = 1'b0;
      repeat (20) @(negedge i_ref_clk);
      i_reset_n = 1'b1;
      @(negedge i_ref_clk);
      check(o_serial_port_mode, 20'h00000);
      check(o_grp_b_frame_len, 9'h010);
      check(o_xfer_ready, 1'b1);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_fields();
      wr(20'hfffff);
      check(o_serial_port_mode, 20'h87fff);
      check({o_spdif_out_enable, o_grp_b_use_pll, o_grp_b_bit_clock_oe, o_grp_a_tdm}, 4'hf);
      @(negedge i_ref_clk);
      i_xfer_write = 1'b1;
      i_xfer_data  = 20'h7ffff;
      @(negedge i_ref_clk);
      i_xfer_data  = 20'h01000;
      wr(20'h01000);
      check(o_serial_port_mode, 20'h01000);
      check({o_spdif_out_enable, o_shared_serial_clock_oe, o_grp_a_bit_clock_oe, o_grp_b_tdm}, 4'h4);
      $display("t_fields done");
   endtask : t_fields
   task automatic t_words();
      for (int k = 0; k < 8; k++) begin
         i_grp_a_precision_lo = k[1];
         i_grp_b_precision_lo = k[1];
         wr(20'((7 - k) * 8 + k) | (k[0] ? 20'h06000 : 20'h00000));
         check(o_grp_a_precision, PRECS[k % 4]);
         check(o_grp_b_precision, PRECS[k % 4]);
         check(o_grp_a_frame_len, LENS[k]);
         check(o_grp_b_frame_len, LENS[7 - k]);
      end
      $display("t_words done");
   endtask : t_words
   task automatic t_pins();
      int         edges, hits_a, hits_b;
      logic       prev;
      logic [7:0] hist;
      for (int p = 0; p < 2; p++) begin
         wr(p ? 20'h000c0 : 20'h00000);
         i_port_grouping_select = p[0];
         i_grp_b_sync_select    = p[0];
         {edges, hits_a, hits_b, prev, hist} = 105'h0;
         run = 1'b1;
         for (int n = 0; n < 400; n++) begin
            @(negedge i_ref_clk);
            if (n == 300) run = 1'b0;
            hist = {hist[6:0], i_grp_a_bit_clock && !prev};
            edges += int'(hist[0]);
            prev = i_grp_a_bit_clock;
            // A pulse counts only two samples after a rise or six after, at the fall
            hits_a += int'(o_grp_a_sample_pulse && hist[p ? 6 : 2]);
            hits_b += int'(o_grp_b_launch_pulse && hist[p ? 2 : 6]);
         end
         check(hits_a, edges);
         check(hits_b, edges);
         check({o_grp_a_channel_flag, o_grp_b_channel_flag}, {2{i_grp_a_word_sel}});
         check({o_port_f_in_grp_a, o_grp_b_word_sync}, {!p[0], p[0]});
      end
      $display("t_pins done");
   endtask : t_pins
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   initial begin
      {i_reset_n, i_xfer_write, i_xfer_data, run} = 23'h0;
      {i_grp_a_precision_lo, i_grp_b_precision_lo} = 2'h0;
      {i_port_grouping_select, i_grp_b_sync_select} = 2'h0;
      {bad_count, n_checks} = 64'h0;
      repeat (20) @(negedge i_ref_clk);
      i_reset_n = 1'b1;
      t_reset();
      t_fields();
      t_words();
      t_pins();
      end_of_test();
   end
   initial begin
      #50000;
      bad_count++;
      end_of_test();
   end
endmodule : serial_port_mode_ctrl_tb_top
